/* verilog/vpic_ctrl.sv */
// vectored eight-level priority interrupt controller core
`include "vpic_map.svh"
module vpic_ctrl
  import vpic_pkg::*;
#(
  parameter int NSRC = `VPIC_NSRC
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rstn_i,
  input  wire logic [NSRC-1:0]    src_i,          // raw source levels, async
  input  wire logic [NSRC-1:0]    enable_i,       // per-source unmask
  input  wire logic [2*NSRC-1:0]  trig_i,         // vpic_trig_t per source
  input  wire logic [3*NSRC-1:0]  prio_i,         // priority per source
  input  wire logic [NSRC-1:0]    fast_force_i,   // redirect to fast line
  input  wire logic               gen_mask_i,     // holds both lines high
  input  wire logic               protect_i,      // reads have no side effect
  input  wire logic               vec_we_i,       // vector write strobe
  input  wire logic [4:0]         vec_waddr_i,
  input  wire logic [31:0]        vec_wdata_i,
  input  wire logic               ivr_rd_i,       // acknowledge read strobe
  input  wire logic               eoi_i,          // end of service strobe
  input  wire logic [NSRC-1:0]    clr_i,          // clears edge pending
  output logic                    normal_irq_line_n_o,
  output logic                    fast_irq_line_n_o,
  output logic [31:0]             ivr_o,          // vector of serviced source
  output logic [4:0]              cur_src_o,
  output logic [NSRC-1:0]         pending_o,
  output logic [3:0]              depth_o         // nesting depth
);
  localparam int PW = `VPIC_PRIO_W;
  logic [NSRC-1:0] s1_r, s2_r, s3_r, lvl, edg, pend_r, pend_nxt;
  logic [31:0]     vec_r [NSRC];
  logic [31:0]     vec_nxt [NSRC];
  // stack of serviced source/priority, eight levels deep
  logic [4:0]      stk_src_r [8];
  logic [4:0]      stk_src_nxt [8];
  logic [PW:0]     stk_pri_r [8];
  logic [PW:0]     stk_pri_nxt [8];
  logic [3:0]      dep_r, dep_nxt;
  logic [31:0]     ivr_r, ivr_nxt;
  logic            normal_irq_line_n_r, normal_irq_line_n_nxt, fast_irq_line_n_r, fast_irq_line_n_nxt;
  logic [4:0]      win;
  logic [PW-1:0]   win_pri;
  logic            win_ok;
  logic [PW:0]     cur_pri;
  logic [NSRC-1:0] cand;

  // source polarity and edge detect, per source
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      logic pol_high, is_edge;
      assign pol_high = trig_i[2*g+1];
      assign is_edge  = trig_i[2*g];
      assign lvl[g] = pol_high ? s2_r[g] : ~s2_r[g];
      assign edg[g] = is_edge & (pol_high ? (s2_r[g] & ~s3_r[g]) : (~s2_r[g] & s3_r[g]));
    end
  endgenerate

  // current priority: top of stack, all ones when idle (idle tested apart)
  assign cur_pri = (dep_r == 4'h0) ? '1 : stk_pri_r[dep_r[2:0] - 3'h1];

  // resolver over unmasked normal sources; source 0 never here
  always_comb begin
    win     = 5'h00;
    win_pri = '0;
    win_ok  = 1'b0;
    cand    = pend_r & enable_i & ~fast_force_i;
    cand[`VPIC_SRC_FAST] = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (cand[i] && (!win_ok || prio_i[PW*i +: PW] > win_pri)) begin
        win     = 5'(i);
        win_pri = prio_i[PW*i +: PW];
        win_ok  = 1'b1;
      end
    end
  end

  // pending, vectors, stack and line state
  always_comb begin
    pend_nxt    = pend_r;
    vec_nxt     = vec_r;
    stk_src_nxt = stk_src_r;
    stk_pri_nxt = stk_pri_r;
    dep_nxt     = dep_r;
    ivr_nxt     = ivr_r;
    for (int i = 0; i < NSRC; i++) begin
      // edge pending: set beats clear
      if (trig_i[2*i]) begin
        if (clr_i[i])
          pend_nxt[i] = 1'b0;
        if (edg[i])
          pend_nxt[i] = 1'b1;
      end else begin
        pend_nxt[i] = lvl[i];
      end
    end
    if (vec_we_i)
      vec_nxt[vec_waddr_i] = vec_wdata_i;
    // end of service pops one level
    if (eoi_i && dep_r != 4'h0)
      dep_nxt = dep_r - 4'h1;
    // acknowledge read; protect mode suppresses push
    if (ivr_rd_i) begin
      ivr_nxt = `VPIC_SPURIOUS;
      if (win_ok && ({1'b0, win_pri} > cur_pri || dep_r == 4'h0) && dep_r < 4'h8) begin
        ivr_nxt = vec_r[win];
        if (!protect_i) begin
          stk_src_nxt[dep_nxt[2:0]] = win;
          stk_pri_nxt[dep_nxt[2:0]] = {1'b0, win_pri};
          dep_nxt = dep_nxt + 4'h1;  // push on top of a same-cycle pop
          if (trig_i[2*win] && !edg[win])
            pend_nxt[win] = 1'b0;
        end
      end
    end
    // lines active low, gated by general mask
    normal_irq_line_n_nxt = ~(~gen_mask_i & win_ok &
                 ((dep_r == 4'h0) || ({1'b0, win_pri} > cur_pri)));
    // fast line from pin source and forced sources
    fast_irq_line_n_nxt = ~(~gen_mask_i & |(pend_r & enable_i & (fast_force_i | NSRC'(1))));
  end

  // registers
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      pend_r <= '0;
      dep_r  <= 4'h0;
      ivr_r  <= 32'h0000_0000;
      normal_irq_line_n_r <= 1'b1;
      fast_irq_line_n_r <= 1'b1;
      for (int i = 0; i < NSRC; i++)
        vec_r[i] <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        stk_src_r[i] <= 5'h00;
        stk_pri_r[i] <= '0;
      end
    end else begin
      s1_r      <= src_i;
      s2_r      <= s1_r;
      s3_r      <= s2_r;
      pend_r    <= pend_nxt;
      dep_r     <= dep_nxt;
      ivr_r     <= ivr_nxt;
      normal_irq_line_n_r    <= normal_irq_line_n_nxt;
      fast_irq_line_n_r    <= fast_irq_line_n_nxt;
      vec_r     <= vec_nxt;
      stk_src_r <= stk_src_nxt;
      stk_pri_r <= stk_pri_nxt;
    end
  end

  // numbering is positional: bit n is source n
  assign normal_irq_line_n_o = normal_irq_line_n_r;
  assign fast_irq_line_n_o   = fast_irq_line_n_r;
  assign ivr_o               = ivr_r;
  assign cur_src_o           = (dep_r == 4'h0) ? 5'h00 : stk_src_r[dep_r[2:0] - 3'h1];
  assign pending_o           = pend_r;
  assign depth_o             = dep_r;

  a_gen_mask_quiet: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $past(gen_mask_i) |-> normal_irq_line_n_o && fast_irq_line_n_o)
    else $error("request line active under general mask");
  a_protect_depth: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ivr_rd_i && protect_i && !eoi_i |=> $stable(depth_o))
    else $error("protected read changed depth");
  // unmasked winning source raises normal line at idle
  a_normal_raise: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    win_ok && dep_r == 4'h0 && !gen_mask_i |=> !normal_irq_line_n_o)
    else $error("normal line not raised");
  // fast pin source drives fast line
  a_fast_pin: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pend_r[0] && enable_i[0] && !gen_mask_i |=> !fast_irq_line_n_o)
    else $error("fast line not raised");
  a_vector_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ivr_rd_i && !protect_i && !eoi_i && win_ok && dep_r == 4'h0 |=> ivr_o == vec_r[cur_src_o])
    else $error("vector read mismatch");
  a_eoi_pop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    eoi_i && !ivr_rd_i && dep_r != 4'h0 |=> depth_o == $past(depth_o) - 4'h1)
    else $error("eoi did not pop");
  a_no_equal_nest: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    dep_r != 4'h0 && win_ok && {1'b0, win_pri} <= cur_pri |=> normal_irq_line_n_o)
    else $error("equal priority nested");
  // forced source stays off normal line
  a_forced_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    win_ok |-> !fast_force_i[win])
    else $error("forced source won normal arbitration");
  a_depth_bound: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    depth_o <= 4'h8)
    else $error("nesting depth beyond eight");
  a_nest_raise: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    dep_r != 4'h0 && win_ok && {1'b0, win_pri} > cur_pri && !gen_mask_i |=> !normal_irq_line_n_o)
    else $error("higher priority did not nest");
  // read with nothing to serve gives spurious vector
  a_spurious_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ivr_rd_i && !win_ok |=> ivr_o == `VPIC_SPURIOUS)
    else $error("spurious read returned a vector");
  a_forced_fast: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    |(pend_r & enable_i & fast_force_i) && !gen_mask_i |=> !fast_irq_line_n_o)
    else $error("forced source missed fast line");
  // end of service at idle keeps depth zero
  a_eoi_idle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    eoi_i && !ivr_rd_i && dep_r == 4'h0 |=> depth_o == 4'h0)
    else $error("end of service at idle moved depth");
  // first acknowledge pushes, source becomes current
  sequence s_first_ack;
    ivr_rd_i && !protect_i && !eoi_i && win_ok && dep_r == 4'h0;
  endsequence
  a_first_push: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_first_ack |=> depth_o == 4'h1 && cur_src_o == $past(win))
    else $error("first acknowledge did not push");
endmodule

/* verilog/vpic_map.svh */
// constants for the vectored priority interrupt controller
// Behaviour
// - drive active-low normal and fast request lines
// - per-source mask and per-source vector
// - source zero is the fast input pin
// - source one is system peripherals combined
// - internal sources edge or level selectable
// - external sources rise, fall, high, low
// - eight-level priority resolver raises normal request
// - strictly higher priority nests over current service
// - writable 32-bit vector per source
// - vector read returns serviced source vector
// - protect mode blocks read side effects
// - fast forcing redirects source to fast line
// - general mask silences both lines, pending visible
// - sources 2-19 peripherals, 30-31 external pins
`ifndef VPIC_MAP_SVH
`define VPIC_MAP_SVH
`define VPIC_NSRC        32
`define VPIC_SRC_FAST    5'h00
`define VPIC_SRC_SYS     5'h01
`define VPIC_SRC_PER_LO  5'h02
`define VPIC_SRC_PER_HI  5'h13
`define VPIC_SRC_EXT0    5'h1e
`define VPIC_SRC_EXT1    5'h1f
`define VPIC_PRIO_W      3
`define VPIC_SPURIOUS    32'h0000_0000
`endif

/* verilog/vpic_pkg.sv */
// types for the vectored priority interrupt controller
package vpic_pkg;
  // trigger mode: internal sources use the polarity bit as well as the edge bit, like external ones
  typedef enum logic [1:0] {
    VPIC_LVL_LOW  = 2'h0,
    VPIC_EDGE_NEG = 2'h1,
    VPIC_LVL_HIGH = 2'h2,
    VPIC_EDGE_POS = 2'h3
  } vpic_trig_t;
endpackage

/* sim/vpic_core_model.sv */
// processor core model: acknowledges requests, ends service later
module vpic_core_model (
  input  wire logic       ref_clk_i,
  input  wire logic       irq_n_i,
  input  wire logic [7:0] svc_i,
  output logic            ivr_rd_o,
  output logic            eoi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ack on a low line, held across one sampling edge
  initial begin
    ivr_rd_o = 0;
    eoi_o = 0;
    forever begin
      // line is read once it has settled after the edge
      @(posedge ref_clk_i);
      #5;
      if (irq_n_i === 1'b0) begin
        ivr_rd_o = 1;
        @(posedge ref_clk_i) #5 ivr_rd_o = 0;
        fork begin
          repeat (svc_i) @(posedge ref_clk_i);
          #5 eoi_o = 1;
          @(posedge ref_clk_i) #5 eoi_o = 0;
        end join_none
      end
    end
  end
endmodule

/* sim/vectored_priority_irq_ctrl_test.sv */
// self-checking bench for the interrupt controller
`include "vpic_map.svh"
module vectored_priority_irq_ctrl_test;
  import vpic_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, gm = 0, we = 0, rd, eoi, rd_d = 0, nl, fl;
  logic brd = 0, prot = 0;
  logic [31:0] src = 32'h4000_0000, en = 0, ff = 0, clr = 0, wd = 0, ivr, pnd;
  logic [63:0] trig = 0;
  logic [95:0] prio = 0;
  logic [4:0] wa = 0, cur;
  logic [3:0] dep;
  logic [7:0] svc = 8'h04;
  logic [31:0] vec [32];
  logic [31:0] q [$];
  int error_cnt = 0, checks_done = 0, cycles = 0;
  vpic_ctrl vpic_ctrl_inst (.ref_clk_i(clk), .rstn_i(rstn), .src_i(src), .enable_i(en), .trig_i(trig),
    .prio_i(prio), .fast_force_i(ff), .gen_mask_i(gm), .protect_i(prot), .vec_we_i(we), .vec_waddr_i(wa),
    .vec_wdata_i(wd), .ivr_rd_i(rd | brd), .eoi_i(eoi), .clr_i(clr), .normal_irq_line_n_o(nl),
    .fast_irq_line_n_o(fl), .ivr_o(ivr), .cur_src_o(cur), .pending_o(pnd), .depth_o(dep));
  vpic_core_model vpic_core_model_inst (.ref_clk_i(clk), .irq_n_i(nl), .svc_i(svc), .ivr_rd_o(rd),
    .eoi_o(eoi));
  always #50 clk = ~clk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic setup(int s, logic [1:0] t, logic [2:0] p);
    trig[2*s+:2] = t;
    prio[3*s+:3] = p;
    // drop any pending left over from the previous trigger mode
    clr[s] = 1;
    cyc(1);
    clr[s] = 0;
    en[s] = 1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // scoreboard: vector seen one edge after each acknowledge
  always @(posedge clk) begin
    if (rd_d) begin
      if (q.size() == 0) chk(ivr, `VPIC_SPURIOUS);
      else chk(ivr, q.pop_front());
    end
    rd_d <= rd | brd;
    if (++cycles > 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    void'($urandom(54233));
    cyc(6);
    rstn = 1;
    for (int i = 0; i < 32; i++) begin
      vec[i] = $urandom();
      we = 1; wa = 5'(i); wd = vec[i];
      cyc(1);
    end
    we = 0;
    setup(5, VPIC_EDGE_POS, 3'h3);
    q.push_back(vec[5]);
    src[5] = 1;
    cyc(20);
    chk(dep, 4'h0);
    $display("rising edge test done");
    svc = 8'h1e;
    setup(6, VPIC_EDGE_POS, 3'h1);
    setup(7, VPIC_EDGE_POS, 3'h6);
    q.push_back(vec[6]);
    q.push_back(vec[7]);
    src[6] = 1;
    cyc(8);
    src[7] = 1;
    cyc(10);
    chk(dep, 4'h2);
    chk(cur, 5'h07);
    cyc(60);
    chk(dep, 4'h0);
    $display("nesting test done");
    svc = 8'h04;
    trig[17:16] = VPIC_EDGE_POS;
    src[8] = 1;
    cyc(8);
    chk(nl, 1'b1);
    gm = 1;
    setup(9, VPIC_EDGE_POS, 3'h2);
    setup(31, VPIC_LVL_LOW, 3'h2);
    src[9] = 1;
    src[31] = 0;
    cyc(8);
    chk({nl, fl, pnd[9], pnd[31]}, 4'hf);
    // debugger read under mask: vector returned, no push, pending kept
    q.push_back(vec[9]);
    prot = 1;
    brd = 1;
    cyc(1);
    brd = 0;
    prot = 0;
    chk(dep, 4'h0);
    chk(pnd[9], 1'b1);
    src[31] = 1;
    cyc(6);
    chk(pnd[31], 1'b0);
    q.push_back(vec[9]);
    gm = 0;
    cyc(20);
    chk(pnd[9], 1'b0);
    $display("mask test done");
    setup(0, VPIC_LVL_HIGH, 3'h7);
    src[0] = 1;
    cyc(6);
    chk({fl, nl}, 2'h1);
    src[0] = 0;
    setup(12, VPIC_EDGE_POS, 3'h4);
    ff[12] = 1;
    src[12] = 1;
    cyc(8);
    chk({fl, nl}, 2'h1);
    clr[12] = 1;
    cyc(1);
    clr[12] = 0;
    cyc(3);
    chk(fl, 1'b1);
    $display("fast test done");
    setup(30, VPIC_EDGE_NEG, 3'h5);
    q.push_back(vec[30]);
    src[30] = 0;
    cyc(20);
    chk(q.size(), 32'h0);
    $display("external pin test done");
    close_out();
  end
endmodule
